// ### hdl/ttsb_pkg.sv
// Package with constants and types for the trail trace string builder and checker.
// What this block does
// R1 - Fixed 64-byte string, bytes indexed 0 to 63.
// R2 - Byte 0 always transmitted as zero.
// R3 - Bytes 1-15 carry source identifier characters.
// R4 - Byte 16 always transmitted as zero.
// R5 - Bytes 17-31 carry destination identifier characters.
// R6 - Bytes 32-63 operator content, passed unchecked.
// R7 - Identifier: three country, twelve national characters.
// R8 - Characters are 7-bit code, one per byte.
// R9 - Country segment uses uppercase letters only.
// R10 - National segment: carrier code, then point code.
// R11 - Carrier code 1-6 chars, alpha then numeric.
// R12 - Point code 6-11 chars, NUL padded to twelve.
// R13 - Receive identifiers compared; mismatch flag is sticky.
package ttsb_pkg;
   localparam int          TTSB_LEN       = 64;     // String length in bytes.
   localparam int          TTSB_IDX_W     = 6;      // Width of a byte index.
   localparam logic [5:0]  TTSB_SRC_LEAD  = 6'h00;  // Source identifier lead byte.
   localparam logic [5:0]  TTSB_SRC_LAST  = 6'h0f;  // Last source identifier byte.
   localparam logic [5:0]  TTSB_DST_LEAD  = 6'h10;  // Destination identifier lead byte.
   localparam logic [5:0]  TTSB_DST_LAST  = 6'h1f;  // Last destination identifier byte.
   localparam logic [5:0]  TTSB_OPR_FIRST = 6'h20;  // First operator byte.
   localparam int          TTSB_CC_LEN    = 3;      // Country segment characters.
   localparam int          TTSB_NS_LEN    = 12;     // National segment characters.
   localparam int          TTSB_CAR_MIN   = 1;      // Shortest carrier code.
   localparam int          TTSB_CAR_MAX   = 6;      // Longest carrier code.
   localparam int          TTSB_UPC_MIN   = 6;      // Shortest point code.
   localparam logic [7:0]  TTSB_NUL       = 8'h00;  // Padding and lead character.
   localparam logic [7:0]  TTSB_UP_A      = 8'h41;  // Uppercase A.
   localparam logic [7:0]  TTSB_UP_Z      = 8'h5a;  // Uppercase Z.
   localparam logic [7:0]  TTSB_LO_A      = 8'h61;  // Lowercase a.
   localparam logic [7:0]  TTSB_LO_Z      = 8'h7a;  // Lowercase z.
   localparam logic [7:0]  TTSB_DIG_0     = 8'h30;  // Digit 0.
   localparam logic [7:0]  TTSB_DIG_9     = 8'h39;  // Digit 9.

   // One byte of the string with its position and a valid flag.
   typedef struct packed {
      logic       valid;
      logic [5:0] idx;
      logic [7:0] data;
   } ttsb_byte_type;

   // Format checker state for one identifier.
   typedef enum logic [1:0] {TTSB_CC, TTSB_CAR_A, TTSB_CAR_N, TTSB_UPC} ttsb_fmt_st_type;
   typedef struct packed {
      ttsb_fmt_st_type st;
      logic [3:0]      pos;     // Character number within identifier, 1 to 15.
      logic [3:0]      car;     // Carrier characters seen.
      logic [3:0]      upc;     // Point code characters before padding.
      logic            pad;     // Padding started.
      logic            bad;     // Format fault seen in this identifier.
      logic            done;    // One-cycle verdict pulse.
      logic            ok;      // Verdict value.
   } ttsb_fmt_type;
endpackage : ttsb_pkg

// ### hdl/ttsb_fmt_check.sv
// Format checker for one fifteen-character access point identifier.
`timescale 1ns/1ns
module ttsb_fmt_check (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  ce_i,
   input  wire logic                  start_i,   // Lead byte seen, restart check.
   input  wire logic                  chr_vld_i, // Identifier character present.
   input  wire logic [7:0]            chr_i,     // The character.
   output logic                       done_o,    // Verdict pulse after character 15.
   output logic                       ok_o       // Verdict, held until next one.
);
   import ttsb_pkg::*;

   ttsb_fmt_type r, nxt;  // Whole state and its next value.
   logic up, lo, dig, alpha;

   // Character classes; bit 7 set is never a valid 7-bit character.
   always_comb begin
      up    = chr_i >= TTSB_UP_A && chr_i <= TTSB_UP_Z;
      lo    = chr_i >= TTSB_LO_A && chr_i <= TTSB_LO_Z;
      dig   = chr_i >= TTSB_DIG_0 && chr_i <= TTSB_DIG_9;
      alpha = up || lo;
   end

   // Walk the identifier one character at a time.
   always_comb begin
      nxt      = r;
      nxt.done = 1'b0;
      if (start_i) begin
         nxt.st  = TTSB_CC;
         nxt.pos = 4'h1;
         nxt.car = 4'h0;
         nxt.upc = 4'h0;
         nxt.pad = 1'b0;
         nxt.bad = 1'b0;
      end else if (chr_vld_i) begin
         nxt.pos = r.pos + 4'h1;
         // R8 seven bit code
         if (chr_i[7])
            nxt.bad = 1'b1;
         case (r.st)
            TTSB_CC: begin
               // R9 uppercase country letters
               if (!up)
                  nxt.bad = 1'b1;
               // R7 three then twelve
               if (r.pos == 4'(TTSB_CC_LEN))
                  nxt.st = TTSB_CAR_A;
            end
            TTSB_CAR_A: begin
               // R11 carrier starts alphabetic
               if (alpha && r.car < 4'(TTSB_CAR_MAX)) begin
                  nxt.car = r.car + 4'h1;
               end else if (dig && r.car != 4'h0 && r.car < 4'(TTSB_CAR_MAX)) begin
                  nxt.car = r.car + 4'h1;
                  nxt.st  = TTSB_CAR_N;
               end else begin
                  // R10 point code follows carrier
                  nxt.st  = TTSB_UPC;
                  nxt.upc = 4'h1;
                  if (r.car < 4'(TTSB_CAR_MIN) || chr_i == TTSB_NUL)
                     nxt.bad = 1'b1;
               end
            end
            TTSB_CAR_N: begin
               // R11 numeric tail of carrier
               if (dig && r.car < 4'(TTSB_CAR_MAX)) begin
                  nxt.car = r.car + 4'h1;
               end else begin
                  nxt.st  = TTSB_UPC;
                  nxt.upc = 4'h1;
                  if (chr_i == TTSB_NUL)
                     nxt.bad = 1'b1;
               end
            end
            default: begin
               // R12 point code then padding
               if (chr_i == TTSB_NUL)
                  nxt.pad = 1'b1;
               else if (r.pad)
                  nxt.bad = 1'b1;
               else
                  nxt.upc = r.upc + 4'h1;
            end
         endcase
         if (r.pos == 4'hf) begin
            nxt.done = 1'b1;
            // R12 point code length
            nxt.ok   = !nxt.bad && nxt.st == TTSB_UPC && nxt.upc >= 4'(TTSB_UPC_MIN);
         end
      end
   end

   // Register the state; clock enable freezes it.
   always_ff @(posedge clk_i) begin
      if (rst_i)
         r <= '{st: TTSB_CC, pos: 4'h1, car: 4'h0, upc: 4'h0, pad: 1'b0,
                bad: 1'b0, done: 1'b0, ok: 1'b0};
      else if (ce_i)
         r <= nxt;
   end

   assign done_o = r.done;
   assign ok_o   = r.ok;

   a_cc_upper: assert property (@(posedge clk_i) disable iff (rst_i) // R9
      ce_i && chr_vld_i && !start_i && r.st == TTSB_CC && !up |=> r.bad)
      else $error("lowercase country letter not flagged");
   a_hibit_bad: assert property (@(posedge clk_i) disable iff (rst_i) // R8
      ce_i && chr_vld_i && !start_i && chr_i[7] |=> r.bad)
      else $error("eighth bit not flagged");
   a_upc_short: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      r.done && r.ok |-> r.upc >= 4'(TTSB_UPC_MIN))
      else $error("short point code accepted");
   a_car_max: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      r.car <= 4'(TTSB_CAR_MAX))
      else $error("carrier code too long");
endmodule : ttsb_fmt_check

// ### hdl/ttsb_top.sv
// Trail trace string builder for transmit and checker for receive.
`timescale 1ns/1ns
module ttsb_top #(
   parameter int LEN = ttsb_pkg::TTSB_LEN  // String length; only 64 is served.
) (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    ce_i,
   // Transmit side: inserter asks for byte index, gets data next cycle.
   input  wire logic                    tx_req_i,
   input  wire logic [5:0]              tx_idx_i,
   output ttsb_pkg::ttsb_byte_type      tx_byte_o,
   // Expected or transmitted identifier contents, characters 1..15 each.
   input  wire logic [15*8-1:0]         src_id_i,
   input  wire logic [15*8-1:0]         dst_id_i,
   input  wire logic [32*8-1:0]         opr_i,
   // Receive side: extractor delivers bytes with their index.
   input  ttsb_pkg::ttsb_byte_type      rx_byte_i,
   input  wire logic                    mis_clr_i,
   output logic                         src_mis_o,
   output logic                         dst_mis_o,
   output logic                         src_fmt_ok_o,
   output logic                         dst_fmt_ok_o,
   output logic [32*8-1:0]              rx_opr_o
);
   import ttsb_pkg::*;

   // The index width and section bounds only suit a 64 byte string.
   if (LEN != TTSB_LEN) begin : g_len_chk
      $error("ttsb_top: only a 64 byte string is supported");
   end

   // All block state in one struct.
   // The operator capture is wide but only written here, never compared.
   typedef struct packed {
      ttsb_byte_type   tx;
      logic            src_mis;
      logic            dst_mis;
      logic [255:0]    opr;
   } ttsb_state_type;

   ttsb_state_type r, nxt;   // Registered state and its next value.
   logic [7:0]  exp_chr;     // Expected character at the received index.
   logic        in_src;      // Received byte lies in the source identifier.
   logic        in_dst;      // Received byte lies in the destination identifier.
   logic        s_done, s_ok;  // Source verdict pulse and value.
   logic        d_done, d_ok;  // Destination verdict pulse and value.
   logic [3:0]  chr_no;      // Character number within an identifier.

   // Decode the received position; fixed offsets, nothing searched.
   always_comb begin
      // R1 fixed byte positions
      in_src  = rx_byte_i.valid && rx_byte_i.idx > TTSB_SRC_LEAD
                && rx_byte_i.idx <= TTSB_SRC_LAST;
      in_dst  = rx_byte_i.valid && rx_byte_i.idx > TTSB_DST_LEAD
                && rx_byte_i.idx <= TTSB_DST_LAST;
      chr_no  = rx_byte_i.idx[3:0];
      // Outside the identifiers the expected value is unused; NUL keeps it defined.
      exp_chr = TTSB_NUL;
      // R3 source characters in order
      if (in_src)
         exp_chr = src_id_i[(chr_no - 4'h1)*8 +: 8];
      // R5 destination characters in order
      else if (in_dst)
         exp_chr = dst_id_i[(chr_no - 4'h1)*8 +: 8];
   end

   // Build transmit bytes, compare received ones.
   always_comb begin
      // Start from the held state so untouched fields keep their value.
      nxt          = r;
      // Every request is answered one cycle later with its index echoed,
      // so the inserter can pair each answer with the slot it asked for.
      nxt.tx.valid = tx_req_i;
      nxt.tx.idx   = tx_idx_i;
      if (tx_idx_i == TTSB_SRC_LEAD || tx_idx_i == TTSB_DST_LEAD) begin
         // R2 source lead zero
         // R4 destination lead zero
         nxt.tx.data = TTSB_NUL;
      end else if (tx_idx_i <= TTSB_SRC_LAST) begin
         // R3 source characters sent
         nxt.tx.data = src_id_i[(tx_idx_i[3:0] - 4'h1)*8 +: 8];
      end else if (tx_idx_i <= TTSB_DST_LAST) begin
         // R5 destination characters sent
         nxt.tx.data = dst_id_i[(tx_idx_i[3:0] - 4'h1)*8 +: 8];
      end else begin
         // R6 operator bytes pass through
         nxt.tx.data = opr_i[(tx_idx_i - TTSB_OPR_FIRST)*8 +: 8];
      end
      // Operator bytes received are captured untouched, never checked.
      if (rx_byte_i.valid && rx_byte_i.idx >= TTSB_OPR_FIRST)
         nxt.opr[(rx_byte_i.idx - TTSB_OPR_FIRST)*8 +: 8] = rx_byte_i.data;
      // Clear first so that a mismatch in the same cycle still sets.
      if (mis_clr_i) begin
         nxt.src_mis = 1'b0;
         nxt.dst_mis = 1'b0;
      end
      // R13 sticky mismatch set
      if (in_src && rx_byte_i.data != exp_chr)
         nxt.src_mis = 1'b1;
      if (in_dst && rx_byte_i.data != exp_chr)
         nxt.dst_mis = 1'b1;
   end

   // Register state; clock enable freezes everything.
   // Holding state while ce_i is low lets the caller stall the block mid string.
   always_ff @(posedge clk_i) begin
      if (rst_i)
         r <= '0;
      else if (ce_i)
         r <= nxt;
   end

   // Format checker for the received source identifier.
   ttsb_fmt_check u_src_fmt (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .start_i   (rx_byte_i.valid && rx_byte_i.idx == TTSB_SRC_LEAD),
      .chr_vld_i (in_src),
      .chr_i     (rx_byte_i.data),
      .done_o    (s_done),
      .ok_o      (s_ok)
   );

   // Format checker for the received destination identifier.
   ttsb_fmt_check u_dst_fmt (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .start_i   (rx_byte_i.valid && rx_byte_i.idx == TTSB_DST_LEAD),
      .chr_vld_i (in_dst),
      .chr_i     (rx_byte_i.data),
      .done_o    (d_done),
      .ok_o      (d_ok)
   );

   // Outputs come straight from flip-flops of this block or its checkers.
   assign tx_byte_o    = r.tx;
   assign src_mis_o    = r.src_mis;
   assign dst_mis_o    = r.dst_mis;
   assign src_fmt_ok_o = s_ok;
   assign dst_fmt_ok_o = d_ok;
   assign rx_opr_o     = r.opr;

   // The checks below watch what the block drives; reset masks them all.

   // R2 R4 lead bytes zero
   a_lead_zero: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      ce_i && tx_req_i && (tx_idx_i == TTSB_SRC_LEAD || tx_idx_i == TTSB_DST_LEAD)
      |=> tx_byte_o.valid && tx_byte_o.data == TTSB_NUL)
      else $error("lead byte not zero");

   // R3 source characters placed
   a_src_char: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      ce_i && tx_req_i && tx_idx_i > TTSB_SRC_LEAD && tx_idx_i <= TTSB_SRC_LAST
      |=> tx_byte_o.data == $past(src_id_i[(tx_idx_i[3:0]-4'h1)*8 +: 8]))
      else $error("source character wrong");

   // R5 destination characters placed
   a_dst_char: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      ce_i && tx_req_i && tx_idx_i > TTSB_DST_LEAD && tx_idx_i <= TTSB_DST_LAST
      |=> tx_byte_o.data == $past(dst_id_i[(tx_idx_i[3:0]-4'h1)*8 +: 8]))
      else $error("destination character wrong");

   // R6 operator bytes unchanged
   a_opr_pass: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      ce_i && tx_req_i && tx_idx_i >= TTSB_OPR_FIRST
      |=> tx_byte_o.data == $past(opr_i[(tx_idx_i-TTSB_OPR_FIRST)*8 +: 8]))
      else $error("operator byte altered");

   // R1 index echoed back
   a_idx_echo: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      ce_i && tx_req_i |=> tx_byte_o.idx == $past(tx_idx_i))
      else $error("byte index not echoed");

   // R1 no request, no byte
   a_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      ce_i && !tx_req_i |=> !tx_byte_o.valid)
      else $error("byte offered without a request");

   // R6 first operator byte captured
   a_opr_capture: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      ce_i && rx_byte_i.valid && rx_byte_i.idx == TTSB_OPR_FIRST
      |=> rx_opr_o[7:0] == $past(rx_byte_i.data))
      else $error("operator byte not captured");

   // R13 source mismatch sets
   a_mis_set: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      ce_i && in_src && rx_byte_i.data != exp_chr |=> src_mis_o)
      else $error("source mismatch lost");

   // R13 source flag sticky
   a_mis_stick: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      src_mis_o && !(ce_i && mis_clr_i) |=> src_mis_o)
      else $error("mismatch flag not sticky");

   // R13 destination mismatch sets
   a_dst_mis: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      ce_i && in_dst && rx_byte_i.data != exp_chr |=> dst_mis_o)
      else $error("destination mismatch lost");

   // R13 destination flag sticky
   a_dst_stick: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      dst_mis_o && !(ce_i && mis_clr_i) |=> dst_mis_o)
      else $error("destination flag not sticky");

   // R13 clear takes effect
   a_mis_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      ce_i && mis_clr_i && !in_src && !in_dst |=> !src_mis_o && !dst_mis_o)
      else $error("mismatch flags not cleared");

   // R13 frozen while disabled
   a_mis_freeze: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      !ce_i |=> $stable(src_mis_o) && $stable(dst_mis_o))
      else $error("flags moved while enable low");

   // Main scenarios that the bench is expected to reach.
   c_tx_lead: cover property (@(posedge clk_i) tx_req_i && tx_idx_i == TTSB_DST_LEAD);
   c_mis:     cover property (@(posedge clk_i) $rose(src_mis_o));
   c_fmt_ok:  cover property (@(posedge clk_i) s_done && s_ok);
   c_fmt_bad: cover property (@(posedge clk_i) d_done && !d_ok);
   c_ce_hold: cover property (@(posedge clk_i) !ce_i && mis_clr_i && src_mis_o);
endmodule : ttsb_top

// ### verification/ttsb_oh_model.sv
// Overhead byte inserter and extractor model that loops the string back.
`timescale 1ns/1ns
module ttsb_oh_model (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                go_i,      // Starts one pass over the string.
   input  wire logic                slow_i,    // Leaves an idle cycle between requests.
   input  wire logic [6:0]          err_idx_i, // Byte flipped on the way back; 64 is none.
   input  ttsb_pkg::ttsb_byte_type  tx_byte_i,
   output logic                     tx_req_o,
   output logic [5:0]               tx_idx_o,
   output ttsb_pkg::ttsb_byte_type  rx_byte_o,
   output logic                     busy_o
);
   import ttsb_pkg::*;
   logic [6:0] cnt_r;  // Next index to ask for; 64 means the pass is over.
   logic       gap_r;  // Set after a request so slow mode skips a cycle.
   logic [1:0] tail_r; // Cycles left for loopback and flags to settle.
   assign busy_o = (cnt_r != 7'h40) || (tail_r != 2'h0);
   // Requests walk the whole string in index order.
   // fixed byte positions
   always_ff @(posedge clk_i) begin
      if (rst_i || go_i) begin
         cnt_r    <= rst_i ? 7'h40 : 7'h00;
         tail_r   <= rst_i ? 2'h0 : 2'h3;
         gap_r    <= 1'b0;
         tx_req_o <= 1'b0;
         tx_idx_o <= 6'h00;
      end else if ((cnt_r != 7'h40) && !(slow_i && gap_r)) begin
         tx_req_o <= 1'b1;
         tx_idx_o <= cnt_r[5:0];
         cnt_r    <= cnt_r + 7'h01;
         gap_r    <= 1'b1;
      end else begin
         // An idle index keeps moving so a stale one is never mistaken for a request.
         tx_req_o <= 1'b0;
         tx_idx_o <= ~tx_idx_o;
         gap_r    <= 1'b0;
         tail_r   <= (cnt_r == 7'h40 && tail_r != 2'h0) ? tail_r - 2'h1 : tail_r;
      end
   end
   // The extractor hands back each sent byte one cycle later.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_byte_o <= '0;
      end else if (tx_byte_i.valid) begin
         rx_byte_o.valid <= 1'b1;
         rx_byte_o.idx   <= tx_byte_i.idx;
         rx_byte_o.data  <= tx_byte_i.data ^ {7'h00, {1'b0, tx_byte_i.idx} == err_idx_i};
      end else begin
         // A released bus shows a changing pattern, not the last byte.
         rx_byte_o.valid <= 1'b0;
         rx_byte_o.idx   <= ~rx_byte_o.idx;
         rx_byte_o.data  <= ~rx_byte_o.data;
      end
   end
endmodule : ttsb_oh_model

// ### verification/ttsb_top_tb_top.sv
// Self-checking bench for the trail trace string builder and checker.
`timescale 1ns/1ns
module ttsb_top_tb_top;
   import ttsb_pkg::*;
   logic            clk_i = 1'b0;
   logic            rst_i, ce_i, tx_req, go, slow, mis_clr, busy;
   logic            src_mis, dst_mis, src_ok, dst_ok;
   logic [5:0]      tx_idx;
   logic [6:0]      err_idx;
   logic [119:0]    src_id, dst_id;
   logic [255:0]    opr, rx_opr;
   ttsb_byte_type   tx_byte, rx_byte;
   ttsb_byte_type   exp_q[$];        // Expected transmit bytes, oldest first.
   int              n_fail = 0;
   int              num_checks = 0;
   logic [31:0]     seed = 32'h2e;   // Fixed start keeps runs repeatable.
   // Identifiers written first character leftmost; good ones first.
   localparam logic [119:0] IDS [8] = '{{"FRAABC.NODE1", 24'h0}, {"USAAB12-77-XYZ", 8'h0},
      {"GBRABCDEF.X-1/2"}, {"frAABC.NODE1", 24'h0}, {"FRAABC.NOD1", 32'h0},
      {"FRAABC.NODE", 8'h0, "12", 8'h0}, {"FRAABC.NO", 8'hc4, "E1", 24'h0},
      {"FRA1BC.NODE1", 24'h0}};
   localparam logic OKS [8] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};

   ttsb_top i_ttsb_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .tx_req_i(tx_req),
      .tx_idx_i(tx_idx), .tx_byte_o(tx_byte), .src_id_i(src_id), .dst_id_i(dst_id),
      .opr_i(opr), .rx_byte_i(rx_byte), .mis_clr_i(mis_clr), .src_mis_o(src_mis),
      .dst_mis_o(dst_mis), .src_fmt_ok_o(src_ok), .dst_fmt_ok_o(dst_ok), .rx_opr_o(rx_opr));
   ttsb_oh_model i_ttsb_oh_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .slow_i(slow),
      .err_idx_i(err_idx), .tx_byte_i(tx_byte), .tx_req_o(tx_req), .tx_idx_o(tx_idx),
      .rx_byte_o(rx_byte), .busy_o(busy));

   // Free-running 20 MHz clock.
   always #25 clk_i = ~clk_i;

   // Counts every comparison and reports each mismatch at once.
   task automatic chk(input logic [255:0] seen, input logic [255:0] want);
      num_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : chk

   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Xorshift step for the operator bytes.
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xs

   // Puts the leftmost character at the lowest byte, as the ports expect.
   function automatic logic [119:0] rev15(input logic [119:0] s);
      logic [119:0] r;
      for (int k = 0; k < 15; k++) r[k*8+:8] = s[(14-k)*8+:8];
      return r;
   endfunction : rev15

   // Byte the string must carry at index k.
   function automatic ttsb_byte_type exp_byte(input int k);
      ttsb_byte_type b;
      b.valid = 1'b1;
      b.idx   = k[5:0];
      if (k == 0 || k == 16) b.data = TTSB_NUL;
      else if (k < 16) b.data = src_id[(k-1)*8+:8];
      else if (k < 32) b.data = dst_id[(k-17)*8+:8];
      else b.data = opr[(k-32)*8+:8];
      return b;
   endfunction : exp_byte

   // Every answered request retires the oldest expected byte.
   always @(posedge clk_i) begin
      if (tx_byte.valid === 1'b1) begin
         if (exp_q.size() == 0) chk(256'h1, 256'h0);
         else chk(256'(tx_byte), 256'(exp_q.pop_front()));
      end
   end

   // One pass of the string out and back, with fresh random operator bytes.
   task automatic run_frame(input logic sl, input logic [6:0] err);
      int k;
      for (k = 0; k < 8; k++) begin
         seed = xs(seed);
         opr[k*32+:32] = seed;
      end
      for (k = 0; k < 64; k++) exp_q.push_back(exp_byte(k));
      slow    = sl;
      err_idx = err;
      go      = 1'b1;
      @(posedge clk_i) #2;
      go = 1'b0;
      for (k = 0; k < 400 && busy === 1'b1; k++) @(posedge clk_i) #2;
      repeat (2) @(posedge clk_i);
      #2;
      chk(256'(k < 400), 256'h1);
      chk(256'(exp_q.size()), 256'h0);
   endtask : run_frame

   // Compares both sticky mismatch flags.
   task automatic flags(input logic sm, input logic dm);
      chk(256'(src_mis), 256'(sm));
      chk(256'(dst_mis), 256'(dm));
   endtask : flags

   // Main sequence: format table, then corrupted loopback and flag clearing.
   initial begin
      rst_i   = 1'b1;
      ce_i    = 1'b1;
      go      = 1'b0;
      slow    = 1'b0;
      err_idx = 7'h40;
      mis_clr = 1'b0;
      opr     = '0;
      src_id  = rev15(IDS[0]);
      dst_id  = rev15(IDS[1]);
      repeat (12) @(posedge clk_i);
      #2;
      rst_i = 1'b0;
      flags(1'h0, 1'h0);
      for (int i = 0; i < 8; i++) begin
         src_id = rev15(IDS[i]);
         dst_id = rev15(IDS[7-i]);
         run_frame(i[0], 7'h40);
         chk(256'(src_ok), 256'(OKS[i]));
         chk(256'(dst_ok), 256'(OKS[7-i]));
         chk(rx_opr, opr);
         flags(1'h0, 1'h0);
      end
      src_id = rev15(IDS[0]);
      dst_id = rev15(IDS[1]);
      run_frame(1'b1, 7'h05);
      flags(1'h1, 1'h0);
      run_frame(1'b0, 7'h14);
      flags(1'h1, 1'h1);
      run_frame(1'b0, 7'h40);
      flags(1'h1, 1'h1);
      // With the clock enable low a clear request must leave the flags alone.
      ce_i    = 1'b0;
      mis_clr = 1'b1;
      @(posedge clk_i) #2;
      @(posedge clk_i) #2;
      flags(1'h1, 1'h1);
      ce_i = 1'b1;
      @(posedge clk_i) #2;
      mis_clr = 1'b0;
      @(posedge clk_i) #2;
      flags(1'h0, 1'h0);
      run_frame(1'b0, 7'h10);
      flags(1'h0, 1'h0);
      run_frame(1'b0, 7'h28);
      flags(1'h0, 1'h0);
      chk(rx_opr, opr ^ (256'h1 << 64));
      run_frame(1'b1, 7'h1f);
      flags(1'h0, 1'h1);
      // A second reset in mid-run clears flags and verdicts; a clean pass follows.
      rst_i = 1'b1;
      @(posedge clk_i) #2;
      rst_i = 1'b0;
      flags(1'h0, 1'h0);
      chk(256'({src_ok, dst_ok}), 256'h0);
      run_frame(1'b0, 7'h40);
      flags(1'h0, 1'h0);
      chk(256'({src_ok, dst_ok}), 256'h3);
      report_and_stop();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #(50 * 20000);
      n_fail++;
      report_and_stop();
   end
endmodule : ttsb_top_tb_top
